// >>> dv/pfd_core_sva.sv
// Checker for the phase detector outputs
`timescale 1ns/1ps
`default_nettype none
module pfd_core_chk
(
    // Inputs
    input wire logic clock, rst_n, divided_reference, divided_vco, polarity_bit,
    input wire logic detector_select_bit, lock_detect_enable_bit, standby_bit,
    input wire logic current_code_high, current_code_low, step_size_or_port_bit,
    input wire logic port_mode, modulus_control,
    // Outputs
    input wire logic pump_source_en, pump_sink_en, pump_hiz, phase_ref_n, phase_vco_n,
    input wire logic lock_indicator,
    input wire logic [6:0] pump_current_pct, prescale_modulus
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence both_low;
        !phase_ref_n && !phase_vco_n;
    endsequence
    coinc_short_a: assert property (both_low |=> phase_ref_n && phase_vco_n)
        else $error("coincident low too long");
    lock_off_a: assert property (!$past(lock_detect_enable_bit) |-> !lock_indicator)
        else $error("lock not low");
    standby_request_lock_a: assert property (
        $past(rst_n && lock_detect_enable_bit && standby_bit) |-> lock_indicator)
        else $error("lock not high");
    lock_and_a: assert property (
        $past(rst_n && lock_detect_enable_bit && !standby_bit && !detector_select_bit)
        |-> lock_indicator == (phase_ref_n && phase_vco_n))
        else $error("lock not line AND");
    pump_hiz_a: assert property (
        $past(standby_bit || !detector_select_bit)
        |-> pump_hiz && !pump_source_en && !pump_sink_en)
        else $error("pump not floating");
    line_rest_a: assert property (
        $past(standby_bit || detector_select_bit) |-> phase_ref_n && phase_vco_n)
        else $error("lines not at rest");
    pump_pct_a: assert property ($past(rst_n) |-> pump_current_pct ==
        ($past(step_size_or_port_bit && !port_mode)
        ? 7'h19 * ($past({current_code_high, current_code_low}) + 7'h01)
        : 7'h46 + 7'h0A * $past({current_code_high, current_code_low})))
        else $error("pump current wrong");
    modulus_a: assert property ($past(rst_n) |->
        prescale_modulus == ($past(modulus_control) ? 7'h40 : 7'h41))
        else $error("modulus wrong");
endmodule // pfd_core_chk
bind pfd_core pfd_core_chk i_pfd_core_chk (.*);
`default_nettype wire

// >>> dv/pfd_vco_model.sv
// Far-side model: divided VCO pulse a set delay after a trigger
`timescale 1ns/1ps
`default_nettype none
module pfd_vco_model
(
    // Trigger
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [3:0] dly,
    // Divided VCO pulse
    output wire logic       divided_vco
);
    int n = -7;
    always @(posedge clock)
        n <= go ? int'(dly) : (n > -7 ? n - 1 : n);
    assign divided_vco = (n <= 0) && (n > -6);
endmodule // pfd_vco_model
`default_nettype wire

// >>> dv/test_pfd_core.sv
// Self-checking bench for the phase detector outputs
`timescale 1ns/1ps
`default_nettype none
module test_pfd_core;
    logic clock = 0, rst_n = 0, divided_reference = 0, go = 0, polarity_bit = 0;
    logic detector_select_bit = 0, lock_detect_enable_bit = 0, standby_bit = 0;
    logic current_code_high = 1, current_code_low = 1, step_size_or_port_bit = 0;
    logic port_mode = 0, modulus_control = 0, divided_vco, pump_source_en, pump_sink_en;
    logic pump_hiz, phase_ref_n, phase_vco_n, lock_indicator;
    logic [6:0] pump_current_pct, prescale_modulus;
    logic [3:0] dly = 0;
    logic [6:0] pct;
    logic [1:0] ev, prev_ev = 0, exp_q[$];
    int bad_count = 0, checks = 0;
    always #2.5 clock = ~clock;
    pfd_core i_pfd_core (.*);
    pfd_vco_model i_pfd_vco_model (.clock(clock), .go(go), .dly(dly), .divided_vco(divided_vco));
    task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task print_verdict;
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Bit 1: source or reference line, bit 0: sink or VCO line
    assign ev = detector_select_bit ? {pump_source_en, pump_sink_en}
                                    : ~{phase_ref_n, phase_vco_n};
    always @(posedge clock)
    begin
        prev_ev <= ev;
        if (rst_n && prev_ev == 0 && ev != 0)
            chk("first pulse", {7'h0, exp_q.size() ? exp_q.pop_front() : 2'bxx}, {7'h0, ev});
    end
    task automatic trial(int rd, int vd, bit lone);
        logic [1:0] e;
        e = (vd < rd) ? 2'b01 : ((vd > rd) ? 2'b10 : 2'b11);
        if (!lone)
            exp_q.push_back((polarity_bit && e != 2'b11) ? ~e : e);
        dly <= 4'(vd);
        go <= 1;
        @(posedge clock);
        go <= 0;
        repeat (rd) @(posedge clock);
        divided_reference <= !lone;
        repeat (6) @(posedge clock);
        divided_reference <= 0;
        repeat (20) @(posedge clock);
    endtask
    initial
    begin
        void'($urandom(32'h666f));
        repeat (2) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        #1 chk("reset outputs", 9'h141, {pump_hiz, lock_indicator, prescale_modulus});
        for (int i = 0; i < 40; i++)
        begin
            // Current codes of both step tables are exercised and checked here
            {polarity_bit, detector_select_bit, lock_detect_enable_bit, step_size_or_port_bit,
             port_mode, modulus_control, current_code_high, current_code_low} <= 8'($urandom);
            repeat (4) @(posedge clock);
            pct = (step_size_or_port_bit && !port_mode)
                ? 7'h19 * ({current_code_high, current_code_low} + 7'h01)
                : 7'h46 + 7'h0A * {current_code_high, current_code_low};
            chk("current", 9'(pct), 9'(pump_current_pct));
            chk("modulus", modulus_control ? 9'h040 : 9'h041, 9'(prescale_modulus));
            trial($urandom % 8, $urandom % 8, 0);
        end
        standby_bit <= 1;
        lock_detect_enable_bit <= 1;
        repeat (8) @(posedge clock);
        chk("standby", 9'h03C, {3'h0, pump_hiz, lock_indicator, phase_ref_n, phase_vco_n,
            pump_source_en, pump_sink_en});
        standby_bit <= 0;
        repeat (4) @(posedge clock);
        trial(0, 0, 1);
        trial(5, 2, 0);
        chk("pending", 9'h0, 9'(exp_q.size()));
        print_verdict();
    end
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule // test_pfd_core
`default_nettype wire

// >>> rtl/pfd_core.v
// Phase/frequency detector outputs with lock indicator
`timescale 1ns/1ps
`default_nettype none
`include "pfd_regs.vh"
module pfd_core
(
    // Clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // Divided pulse trains from outside
    input  wire       divided_reference,
    input  wire       divided_vco,
    // Configuration bits
    input  wire       polarity_bit,
    input  wire       detector_select_bit,
    input  wire       lock_detect_enable_bit,
    input  wire       standby_bit,
    input  wire       current_code_high,
    input  wire       current_code_low,
    input  wire       step_size_or_port_bit,
    input  wire       port_mode,
    input  wire       modulus_control,
    // Single-ended pump drive
    output reg        pump_source_en,
    output reg        pump_sink_en,
    output reg        pump_hiz,
    output reg  [6:0] pump_current_pct,
    // Double-ended lines, active low
    output reg        phase_ref_n,
    output reg        phase_vco_n,
    // Lock indicator and prescaler modulus
    output reg        lock_indicator,
    output reg  [6:0] prescale_modulus
);
    // Recovery states after standby
    localparam [1:0] ST_RUN     = 2'h0;
    localparam [1:0] ST_STANDBY = 2'h1;
    localparam [1:0] ST_WAIT    = 2'h2;

    wire [1:0] pin_in;
    wire [1:0] pin_lvl;
    wire [1:0] pin_edge;
    wire       ref_edge;
    wire       vco_edge;
    wire       both;
    reg        ref_flag;
    reg        vco_flag;
    reg        next_ref_flag;
    reg        next_vco_flag;
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        lead_n;
    reg        lag_n;
    reg  [6:0] next_pct;
    reg  [6:0] next_modulus;
    reg        next_source_en;
    reg        next_sink_en;
    reg        next_hiz;
    reg        next_ref_n;
    reg        next_vco_n;
    reg        next_lock;

    // Channel 0 is the divided reference, channel 1 the divided VCO
    assign pin_in = {divided_vco, divided_reference};

    // Three stages per pin; a level counts once stages two and three agree
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_sync
            reg [2:0] stage;
            reg       seen;
            always @(posedge clock)
            begin
                if (!rst_n)
                begin
                    stage <= 3'h0;
                    seen  <= 1'b0;
                end
                else
                begin
                    stage <= {stage[1:0], pin_in[ch]};
                    if (stage[2] == stage[1])
                        seen <= stage[2];
                end
            end
            assign pin_lvl[ch]  = (stage[2] == stage[1]) ? stage[2] : seen;
            assign pin_edge[ch] = pin_lvl[ch] & ~seen;
        end
    endgenerate

    assign ref_edge = pin_edge[0];
    assign vco_edge = pin_edge[1];
    assign both     = ref_flag & vco_flag;

    // After standby, pulses wait for the first VCO edge, which is consumed
    always @*
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (standby_bit)
                    next_state = ST_STANDBY;
            end
            ST_STANDBY:
            begin
                if (!standby_bit && vco_edge)
                    next_state = ST_RUN;
                else if (!standby_bit)
                    next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (standby_bit)
                    next_state = ST_STANDBY;
                else if (vco_edge)
                    next_state = ST_RUN;
            end
            default:
                next_state = ST_STANDBY;
        endcase
    end

    // Recovery state register
    always @(posedge clock)
    begin
        if (!rst_n)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // Edge-set flags, cleared together once both are set
    always @*
    begin
        next_ref_flag = ref_flag;
        next_vco_flag = vco_flag;
        if (standby_bit || state != ST_RUN)
        begin
            next_ref_flag = 1'b0;
            next_vco_flag = 1'b0;
        end
        else if (both)
        begin
            next_ref_flag = 1'b0;
            next_vco_flag = 1'b0;
        end
        else
        begin
            if (ref_edge)
                next_ref_flag = 1'b1;
            if (vco_edge)
                next_vco_flag = 1'b1;
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            ref_flag <= 1'b0;
            vco_flag <= 1'b0;
        end
        else
        begin
            ref_flag <= next_ref_flag;
            vco_flag <= next_vco_flag;
        end
    end

    // Current step table
    always @*
    begin
        case ({step_size_or_port_bit & ~port_mode, current_code_high, current_code_low})
            3'h0: next_pct = `PFD_FINE_PCT_00;
            3'h1: next_pct = `PFD_FINE_PCT_01;
            3'h2: next_pct = `PFD_FINE_PCT_10;
            3'h3: next_pct = `PFD_FINE_PCT_11;
            3'h4: next_pct = `PFD_COARSE_PCT_00;
            3'h5: next_pct = `PFD_COARSE_PCT_01;
            3'h6: next_pct = `PFD_COARSE_PCT_10;
            default: next_pct = `PFD_COARSE_PCT_11;
        endcase
    end

    // Internal lines: a lone flag pulses its own line, both flags pulse both
    always @*
    begin
        case ({ref_flag, vco_flag})
            2'b01:
            begin
                lead_n = 1'b0;
                lag_n  = 1'b1;
            end
            2'b10:
            begin
                lead_n = 1'b1;
                lag_n  = 1'b0;
            end
            2'b11:
            begin
                lead_n = 1'b0;
                lag_n  = 1'b0;
            end
            default:
            begin
                lead_n = 1'b1;
                lag_n  = 1'b1;
            end
        endcase
    end

    // Output selection by detector select, standby and polarity
    always @*
    begin
        next_modulus = modulus_control ? `PFD_MOD_64 : `PFD_MOD_65;
        if (standby_bit || !detector_select_bit)
        begin
            next_source_en = 1'b0;
            next_sink_en   = 1'b0;
            next_hiz       = 1'b1;
        end
        else
        begin
            next_sink_en   = polarity_bit ? ~lag_n  : ~lead_n;
            next_source_en = polarity_bit ? ~lead_n : ~lag_n;
            next_hiz       = 1'b0;
        end
        if (standby_bit || detector_select_bit)
        begin
            next_ref_n = 1'b1;
            next_vco_n = 1'b1;
        end
        else
        begin
            next_vco_n = polarity_bit ? lag_n  : lead_n;
            next_ref_n = polarity_bit ? lead_n : lag_n;
        end
        if (!lock_detect_enable_bit)
            next_lock = 1'b0;
        else if (standby_bit)
            next_lock = 1'b1;
        else
            next_lock = lead_n & lag_n;
    end

    // Single-ended pump drive registers
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            pump_source_en <= 1'b0;
            pump_sink_en   <= 1'b0;
            pump_hiz       <= 1'b1;
        end
        else
        begin
            pump_source_en <= next_source_en;
            pump_sink_en   <= next_sink_en;
            pump_hiz       <= next_hiz;
        end
    end

    // Double-ended line registers
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            phase_ref_n <= 1'b1;
            phase_vco_n <= 1'b1;
        end
        else
        begin
            phase_ref_n <= next_ref_n;
            phase_vco_n <= next_vco_n;
        end
    end

    // Lock indicator register
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            lock_indicator <= 1'b0;
        end
        else
        begin
            lock_indicator <= next_lock;
        end
    end

    // Current code register
    always @(posedge clock)
    begin
        if (!rst_n)
            pump_current_pct <= `PFD_RST_PCT;
        else
            pump_current_pct <= next_pct;
    end

    // Prescaler modulus register
    always @(posedge clock)
    begin
        if (!rst_n)
            prescale_modulus <= `PFD_RST_MODULUS;
        else
            prescale_modulus <= next_modulus;
    end
endmodule // pfd_core
`default_nettype wire

// >>> rtl/pfd_regs.vh
// Constants for the phase detector and lock output block
`ifndef PFD_REGS_VH
`define PFD_REGS_VH
`define PFD_PCT_W        7
`define PFD_FINE_PCT_00  7'h46
`define PFD_FINE_PCT_01  7'h50
`define PFD_FINE_PCT_10  7'h5A
`define PFD_FINE_PCT_11  7'h64
`define PFD_COARSE_PCT_00 7'h19
`define PFD_COARSE_PCT_01 7'h32
`define PFD_COARSE_PCT_10 7'h4B
`define PFD_COARSE_PCT_11 7'h64
`define PFD_MOD_65       7'h41
`define PFD_MOD_64       7'h40
`define PFD_RST_PCT      7'h46
`define PFD_RST_MODULUS  7'h41
`endif
